// [hdl/wlatch_pkg.sv]
// constants for the serial memory opcode decode and write latch block
// assumes an spi mode 0/3 host; a system clock and a separate link clock
// Functional notes
// R1: set-latch command sets write latch flag
// R2: writes accepted only while latch flag set
// R3: status write data never changes latch flag
// R4: status write or lower write clears latch
// R5: upper-half write leaves latch flag set
// R6: nine-bit address, msb from opcode bit 3
// R7: opcodes 02/03 lower, 0A/0B upper half
// R8: latch flag in status bit 1, reset zero
// R9: status bits 0,4-7 read zero, unwritable
// R10: status bits 2,3 are protect selects
// R11: clear-latch command clears flag, refuses writes
// R12: host should send clear-latch after writes
// R13: msb first, effect only when complete
package wlatch_pkg;
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_RD = 8'h05;
  localparam logic [7:0] OP_STATUS_WR = 8'h01;
  localparam logic [7:0] OP_READ_MASK = 8'hF7;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam int OP_ADDR_HI_BIT = 3;
  localparam int ST_LATCH_BIT = 1;
  localparam int ST_PSEL_LO_BIT = 2;
  localparam int ST_PSEL_HI_BIT = 3;
  localparam logic [7:0] ST_WRITABLE = 8'h0C;
  localparam logic [7:0] ST_RESET = 8'h00;
  localparam logic [8:0] ADDR_RESET = 9'h000;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum logic [2:0] {
    PH_OPCODE = 3'b000,
    PH_ADDR = 3'b001,
    PH_DATA = 3'b011,
    PH_STATUS = 3'b010,
    PH_IGNORE = 3'b110
  } phase_t;
endpackage

// [hdl/sync_bit.sv]
// two-flop synchroniser for one level
// assumes the input is from another clock domain
`timescale 1ns/1ps
module sync_bit (
  input wire logic clk_i, // destination clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic d_i, // asynchronous level
  output logic q_o // synchronised level
);
  logic s1_q;
  logic s1_d;
  logic q_d;
  always_comb begin
    s1_d = d_i;
    q_d = s1_q;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      q_o <= 1'b0;
    end else begin
      s1_q <= s1_d;
      q_o <= q_d;
    end
  end
endmodule

// [hdl/toggle_sync.sv]
// carries a one-cycle event from the link clock to the system clock
// assumes events are spaced by at least a few destination cycles
`timescale 1ns/1ps
module toggle_sync (
  input wire logic clk_i, // destination clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic tog_i, // toggle from source domain
  output logic pulse_o // one-cycle pulse per toggle
);
  logic lvl;
  logic last_q;
  logic last_d;
  logic pulse_d;
  sync_bit u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(tog_i),
    .q_o(lvl)
  );
  always_comb begin
    last_d = lvl;
    pulse_d = lvl ^ last_q;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_q <= 1'b0;
      pulse_o <= 1'b0;
    end else begin
      last_q <= last_d;
      pulse_o <= pulse_d;
    end
  end
endmodule

// [hdl/spi_wlatch.sv]
// spi opcode decode, write latch and status register
// assumes spi mode 0/3: sample on rising sck_i, shift out on falling
// the link logic runs on sck_i; the latch and status live on clock_i
`timescale 1ns/1ps
module spi_wlatch (
  input wire logic clock_i, // system clock, 25 MHz
  input wire logic rst_i, // reset, high; synchronous on clock_i, asynchronous for the event word
  input wire logic sck_i, // spi serial clock (link domain)
  input wire logic cs_n_i, // spi chip select, low active
  input wire logic mosi_i, // spi serial data in
  output logic miso_o, // spi serial data out
  output logic miso_oe_o, // data out enable, high drives
  output logic [7:0] status_o, // status register value
  output logic mem_wr_o, // pulse: accepted array byte write
  output logic mem_rd_o, // pulse: array byte read request
  output logic [8:0] mem_addr_o, // array address of pulse
  output logic [7:0] mem_wdata_o, // array write data
  output logic wr_refused_o // pulse: write refused
);
  // ---------------- link domain ----------------
  // the frame is held in reset while chip select is high, so nothing on
  // sck_i is needed outside a frame; cs_n_i is the async reset of the frame
  logic [2:0] bit_q, bit_d;
  logic [6:0] sh_q, sh_d;
  logic [7:0] op_q, op_d;
  logic [8:0] addr_q, addr_d;
  wlatch_pkg::phase_t ph_q, ph_d;
  logic ev_tog_q, ev_tog_d;
  logic [3:0] ev_kind_q, ev_kind_d;
  logic [8:0] ev_addr_q, ev_addr_d;
  logic [7:0] ev_data_q, ev_data_d;
  logic [7:0] byte_in;
  logic [7:0] tx_q, tx_d;
  logic [7:0] st_link;
  logic we_link;

  // event kinds
  localparam logic [3:0] EV_SET = 4'h1;
  localparam logic [3:0] EV_CLR = 4'h2;
  localparam logic [3:0] EV_SWR = 4'h3;
  localparam logic [3:0] EV_MWR = 4'h4;
  localparam logic [3:0] EV_MRD = 4'h5;
  localparam logic [3:0] EV_END = 4'h6;

  assign byte_in = {sh_q, mosi_i}; // R13
  // status is quasi-static within a frame; read as a sampled snapshot
  assign st_link = status_o;
  assign we_link = status_o[wlatch_pkg::ST_LATCH_BIT];

  always_comb begin
    bit_d = bit_q + 3'h1;
    sh_d = byte_in[6:0];
    op_d = op_q;
    addr_d = addr_q;
    ph_d = ph_q;
    ev_tog_d = ev_tog_q;
    ev_kind_d = ev_kind_q;
    ev_addr_d = ev_addr_q;
    ev_data_d = ev_data_q;
    tx_d = {tx_q[6:0], 1'b0};
    if (bit_q == wlatch_pkg::BIT_LAST) begin
      case (ph_q)
        wlatch_pkg::PH_OPCODE: begin
          op_d = byte_in;
          ph_d = wlatch_pkg::PH_IGNORE;
          if (byte_in == wlatch_pkg::OP_SET_LATCH) begin
            ev_kind_d = EV_SET; // R1
            ev_tog_d = ~ev_tog_q;
          end else if (byte_in == wlatch_pkg::OP_CLR_LATCH) begin
            ev_kind_d = EV_CLR; // R11
            ev_tog_d = ~ev_tog_q;
          end else if (byte_in == wlatch_pkg::OP_STATUS_RD) begin
            ph_d = wlatch_pkg::PH_STATUS;
          end else if (byte_in == wlatch_pkg::OP_STATUS_WR) begin
            ph_d = wlatch_pkg::PH_STATUS;
          end else if ((byte_in & wlatch_pkg::OP_READ_MASK) ==
                       wlatch_pkg::OP_READ ||
                       (byte_in & wlatch_pkg::OP_READ_MASK) ==
                       wlatch_pkg::OP_WRITE) begin
            addr_d = {byte_in[wlatch_pkg::OP_ADDR_HI_BIT], 8'h00}; // R6 R7
            ph_d = wlatch_pkg::PH_ADDR;
          end
        end
        wlatch_pkg::PH_ADDR: begin
          addr_d = {addr_q[8], byte_in}; // R6
          ph_d = wlatch_pkg::PH_DATA;
          if (op_q[0]) begin
            ev_kind_d = EV_MRD;
            ev_addr_d = {addr_q[8], byte_in};
            ev_tog_d = ~ev_tog_q;
          end
        end
        wlatch_pkg::PH_DATA: begin
          addr_d = addr_q + 9'h001;
          if (op_q[0]) begin
            ev_kind_d = EV_MRD;
            ev_addr_d = addr_q + 9'h001;
          end else begin
            ev_kind_d = EV_MWR;
            ev_addr_d = addr_q;
            ev_data_d = byte_in;
          end
          ev_tog_d = ~ev_tog_q;
        end
        wlatch_pkg::PH_STATUS: begin
          if (op_q == wlatch_pkg::OP_STATUS_WR) begin
            ev_kind_d = EV_SWR;
            ev_data_d = byte_in;
            ev_tog_d = ~ev_tog_q;
          end
          ph_d = wlatch_pkg::PH_IGNORE;
        end
        default: ph_d = wlatch_pkg::PH_IGNORE;
      endcase
    end
  end

  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_q <= 3'h0;
      sh_q <= 7'h00;
      op_q <= 8'h00;
      addr_q <= wlatch_pkg::ADDR_RESET;
      ph_q <= wlatch_pkg::PH_OPCODE;
    end else begin
      bit_q <= bit_d;
      sh_q <= sh_d;
      op_q <= op_d;
      addr_q <= addr_d;
      ph_q <= ph_d;
    end
  end

  // event word survives chip select; it is held until the next event
  // system reset clears it so the toggle starts level with its receiver
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      ev_tog_q <= 1'b0;
      ev_kind_q <= 4'h0;
      ev_addr_q <= wlatch_pkg::ADDR_RESET;
      ev_data_q <= 8'h00;
    end else if (!cs_n_i) begin
      ev_tog_q <= ev_tog_d;
      ev_kind_q <= ev_kind_d;
      ev_addr_q <= ev_addr_d;
      ev_data_q <= ev_data_d;
    end
  end

  // shift out on falling sck_i
  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      tx_q <= 8'h00;
    end else if (bit_q == 3'h0 && ph_q == wlatch_pkg::PH_STATUS) begin
      tx_q <= st_link;
    end else begin
      tx_q <= tx_d;
    end
  end

  // ---------------- system domain ----------------
  logic ev_pulse;
  logic cs_n_s;
  logic cs_n_last_q, cs_n_last_d;
  logic [7:0] st_q, st_d;
  logic wr_pend_q, wr_pend_d;
  logic clr_on_end_q, clr_on_end_d;
  logic mem_wr_d, mem_rd_d, refused_d;
  logic [8:0] mem_addr_d;
  logic [7:0] mem_wdata_d;
  logic miso_d, oe_d;

  toggle_sync u_ev (
    .clk_i(clock_i),
    .rst_i(rst_i),
    .tog_i(ev_tog_q),
    .pulse_o(ev_pulse)
  );

  sync_bit u_cs (
    .clk_i(clock_i),
    .rst_i(rst_i),
    .d_i(cs_n_i),
    .q_o(cs_n_s)
  );

  // event word is stable for several system clocks after the toggle
  always_comb begin
    st_d = st_q;
    cs_n_last_d = cs_n_s;
    wr_pend_d = wr_pend_q;
    clr_on_end_d = clr_on_end_q;
    mem_wr_d = 1'b0;
    mem_rd_d = 1'b0;
    refused_d = 1'b0;
    mem_addr_d = mem_addr_o;
    mem_wdata_d = mem_wdata_o;
    // frame-end clear goes first so a latch set in the same cycle wins
    if (cs_n_s && !cs_n_last_q && clr_on_end_q) begin
      st_d[wlatch_pkg::ST_LATCH_BIT] = 1'b0; // R4
      clr_on_end_d = 1'b0;
    end
    if (ev_pulse) begin
      case (ev_kind_q)
        EV_SET: st_d[wlatch_pkg::ST_LATCH_BIT] = 1'b1; // R1
        EV_CLR: st_d[wlatch_pkg::ST_LATCH_BIT] = 1'b0; // R11
        EV_SWR: begin
          if (st_q[wlatch_pkg::ST_LATCH_BIT]) begin // R2
            // only protect selects are writable; latch untouched
            st_d = (st_q & ~wlatch_pkg::ST_WRITABLE) |
                   (ev_data_q & wlatch_pkg::ST_WRITABLE); // R3 R9 R10
            clr_on_end_d = 1'b1; // R4
          end else begin
            refused_d = 1'b1; // R2
          end
        end
        EV_MWR: begin
          if (st_q[wlatch_pkg::ST_LATCH_BIT]) begin // R2
            mem_wr_d = 1'b1;
            mem_addr_d = ev_addr_q;
            mem_wdata_d = ev_data_q;
            // upper-half writes keep the latch set, as the silicon does
            if (!ev_addr_q[8]) begin
              clr_on_end_d = 1'b1; // R4 R5
            end
          end else begin
            refused_d = 1'b1; // R2
          end
        end
        EV_MRD: begin
          mem_rd_d = 1'b1;
          mem_addr_d = ev_addr_q;
        end
        default: ;
      endcase
    end
    wr_pend_d = clr_on_end_d;
    miso_d = tx_q[7];
    oe_d = ~cs_n_s;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_q <= wlatch_pkg::ST_RESET; // R8
      cs_n_last_q <= 1'b1;
      wr_pend_q <= 1'b0;
      clr_on_end_q <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_rd_o <= 1'b0;
      wr_refused_o <= 1'b0;
      mem_addr_o <= wlatch_pkg::ADDR_RESET;
      mem_wdata_o <= 8'h00;
      status_o <= wlatch_pkg::ST_RESET;
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
    end else begin
      st_q <= st_d;
      cs_n_last_q <= cs_n_last_d;
      wr_pend_q <= wr_pend_d;
      clr_on_end_q <= clr_on_end_d;
      mem_wr_o <= mem_wr_d;
      mem_rd_o <= mem_rd_d;
      wr_refused_o <= refused_d;
      mem_addr_o <= mem_addr_d;
      mem_wdata_o <= mem_wdata_d;
      status_o <= st_d;
      miso_o <= miso_d;
      miso_oe_o <= oe_d;
    end
  end
endmodule

// [dv/spi_wlatch_props.sv]
// checker for spi_wlatch: latch, status and pulse relations
// assumes a bind onto the design's top; everything on clock_i
`timescale 1ns/1ps
module spi_wlatch_props (
  input logic clock_i, // system clock
  input logic rst_i, // sync reset
  input logic cs_n_i, // chip select
  input logic [7:0] status_o, // status value
  input logic mem_wr_o, // accepted write
  input logic [8:0] mem_addr_o, // pulse address
  input logic wr_refused_o // refused write
);
  logic pend_q, pend_d, cs_q, cs_d;
  // a lower write waits for its frame end; a new frame forgets it
  always_comb begin
    cs_d = cs_n_i;
    pend_d = pend_q;
    if (mem_wr_o && !mem_addr_o[8]) pend_d = 1'b1;
    else if (cs_q && !cs_n_i) pend_d = 1'b0;
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      pend_q <= pend_d;
      cs_q <= cs_d;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_zero; status_o[7:4] == 4'h0 && !status_o[0]; endproperty
  a_zero: assert property (p_zero) else $error("fixed bits set");
  property p_rst; $fell(rst_i) |-> status_o == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("status after reset");
  property p_wr; mem_wr_o |-> $past(status_o[1]); endproperty
  a_wr: assert property (p_wr) else $error("write with latch off");
  property p_ref; wr_refused_o |-> !status_o[1] && !mem_wr_o; endproperty
  a_ref: assert property (p_ref) else $error("bad refusal");
  property p_up; mem_wr_o && mem_addr_o[8] |=> status_o[1] [*5]; endproperty
  a_up: assert property (p_up) else $error("upper write cleared");
  property p_lo; (pend_q && cs_n_i) [*8] |-> !status_o[1]; endproperty
  a_lo: assert property (p_lo) else $error("lower write kept latch");
  property p_pulse; mem_wr_o |=> !mem_wr_o; endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse long");
endmodule

// [dv/spi_host_model.sv]
// spi host model: mode 0, msb first, link clock only inside frames
// assumes the bench calls sel and xfer one at a time
`timescale 1ns/1ps
module spi_host_model (
  output logic sck_o, // link clock, idles low
  output logic cs_n_o, // chip select, low active
  output logic mosi_o // serial data out
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // nb below 8 cuts a frame short on purpose
  task automatic xfer(input logic [7:0] b, input int nb);
    for (int i = 7; i > 7 - nb; i--) begin
      mosi_o = b[i];
      #3 sck_o = 1'b1;
      #3 sck_o = 1'b0;
    end
    #300; // keeps bytes far enough apart for the system side
  endtask
  task automatic sel(input logic on);
    #7 cs_n_o = ~on;
    if (!on) mosi_o = ~mosi_o; // released line must not look held
    #300;
  endtask
endmodule

// [dv/test_spi_wlatch.sv]
// bench for spi_wlatch: host model drives the link, bench checks
// assumes the host model and checker are compiled before this file
`timescale 1ns/1ps
module test_spi_wlatch;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic sck, cs_n, mosi, miso, miso_oe, wr, rd, refused;
  logic [7:0] status, wdata, last_d;
  logic [8:0] addr, last_wa, last_ra;
  int error_cnt = 0;
  int total_checks = 0;
  int nwr = 0;
  int nref = 0;
  int cycles = 0;
  always #20 clock_i = ~clock_i;
  spi_host_model host_u (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));
  spi_wlatch dut_u (.clock_i(clock_i), .rst_i(rst_i), .sck_i(sck),
    .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
    .status_o(status), .mem_wr_o(wr), .mem_rd_o(rd),
    .mem_addr_o(addr), .mem_wdata_o(wdata), .wr_refused_o(refused));
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] a,
                     input logic [7:0] d, input int n);
    host_u.sel(1'b1);
    host_u.xfer(op, 8);
    if (n > 1) host_u.xfer(a, 8);
    if (n > 2) host_u.xfer(d, 8);
    host_u.sel(1'b0);
    repeat (4) @(posedge clock_i);
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (wr) begin
      nwr++;
      last_wa = addr;
      last_d = wdata;
    end
    if (rd) last_ra = addr;
    if (refused) nref++;
    if (cycles == 3000) begin // the run needs about 550 cycles
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk(24'(status), 24'h00);
    cmd(8'h02, 8'h10, 8'hAA, 3);
    chk(24'(nref), 24'h1);
    cmd(8'h06, 8'h00, 8'h00, 1);
    chk(24'(status), 24'h02);
    cmd(8'h0A, 8'h34, 8'h5A, 3);
    chk(24'({last_wa, last_d}), 24'h1345A);
    chk(24'(status[1]), 24'h1);
    cmd(8'h02, 8'hFF, 8'hC3, 3);
    chk(24'({last_wa, last_d}), 24'h0FFC3);
    chk(24'(status[1]), 24'h0);
    cmd(8'h06, 8'h00, 8'h00, 1);
    cmd(8'h01, 8'hFF, 8'h00, 2);
    chk(24'(status), 24'h0C);
    cmd(8'h01, 8'h00, 8'h00, 2);
    chk(24'(status), 24'h0C);
    chk(24'(nref), 24'h2);
    cmd(8'h06, 8'h00, 8'h00, 1);
    cmd(8'h0A, 8'h01, 8'h11, 3);
    cmd(8'h04, 8'h00, 8'h00, 1);
    chk(24'(status[1]), 24'h0);
    cmd(8'h0A, 8'h02, 8'h22, 3);
    chk(24'(nref), 24'h3);
    chk(24'(nwr), 24'h3);
    cmd(8'h03, 8'h12, 8'h00, 2);
    chk(24'(last_ra), 24'h012);
    cmd(8'h0B, 8'h12, 8'h00, 2);
    chk(24'(last_ra), 24'h112);
    host_u.sel(1'b1);
    host_u.xfer(8'h06, 7);
    host_u.sel(1'b0);
    repeat (4) @(posedge clock_i);
    chk(24'(status[1]), 24'h0);
    cmd(8'h06, 8'h00, 8'h00, 1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk(24'(status), 24'h00);
    stop_test();
  end
endmodule
bind spi_wlatch spi_wlatch_props chk_u (.clock_i(clock_i),
  .rst_i(rst_i), .cs_n_i(cs_n_i), .status_o(status_o),
  .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
  .wr_refused_o(wr_refused_o));
